// >>> include/qstat_regs.svh
// register select codes, field layouts, reset values of the questionable status bank
// What this block does
// R1 - freq bit 0 follows synthesizer unlock
// R2 - freq bit 1 follows 10 MHz reference unlock
// R3 - freq bit 2 follows 1 GHz reference unlock
// R4 - freq bit 3 follows baseband generator unlock
// R5 - freq bit 5 follows sampler loop unlock
// R6 - freq bit 6 follows oscillator loop unlock
// R7 - freq bits 7 to 15 read zero
// R8 - freq bit 4, mod bits 5-15 read zero
// R9 - condition registers track inputs, ignore writes
// R10 - condition read returns bit-weighted integer
// R11 - rise and fall filters select recorded edges
// R12 - software writes filters as summed bit weights
// R13 - enabled transition sets sticky event bit
// R14 - event read returns contents, then clears
// R15 - freq mask gates events onto summary bit 5
// R16 - modulation summary reports into parent bit 7
// R17 - mod bit 0 flags input 1 low
// R18 - mod bit 1 flags input 1 high
// R19 - mod bits 2, 3 flag input 2
// R20 - mod bit 4 flags uncalibrated modulation
// R21 - mod mask gates events onto summary bit 7
// R22 - summary is OR of masked events, every clock
`ifndef QSTAT_REGS_SVH
`define QSTAT_REGS_SVH

`define QS_W             16
// register select codes on the command port
`define QS_SEL_FREQ_COND 4'h0
`define QS_SEL_FREQ_RISE 4'h1
`define QS_SEL_FREQ_FALL 4'h2
`define QS_SEL_FREQ_EVT  4'h3
`define QS_SEL_FREQ_MASK 4'h4
`define QS_SEL_MOD_COND  4'h8
`define QS_SEL_MOD_RISE  4'h9
`define QS_SEL_MOD_FALL  4'ha
`define QS_SEL_MOD_EVT   4'hb
`define QS_SEL_MOD_MASK  4'hc
// condition bit positions
`define QS_F_SYNTH       0
`define QS_F_REF10       1
`define QS_F_REF1G       2
`define QS_F_BB1         3
`define QS_F_SAMPLER     5
`define QS_F_YIG         6
`define QS_M_EXT1_LOW    0
`define QS_M_EXT1_HIGH   1
`define QS_M_EXT2_LOW    2
`define QS_M_EXT2_HIGH   3
`define QS_M_UNCAL       4
// bits that can ever be one
`define QS_FREQ_USED     16'h006f
`define QS_MOD_USED      16'h001f
// reset values
`define QS_RISE_RST      16'h7fff
`define QS_FALL_RST      16'h0000
`define QS_MASK_RST      16'h0000
`define QS_ZERO          16'h0000
// parent questionable condition bit positions
`define QS_PARENT_FREQ   5
`define QS_PARENT_MOD    7

`endif

// >>> include/qstat_pkg.sv
// types shared by the questionable status bank
package qstat_pkg;
  `include "qstat_regs.svh"

  typedef logic [`QS_W-1:0] word_t;

  typedef enum logic [3:0] {
    SEL_FREQ_COND = `QS_SEL_FREQ_COND,
    SEL_FREQ_RISE = `QS_SEL_FREQ_RISE,
    SEL_FREQ_FALL = `QS_SEL_FREQ_FALL,
    SEL_FREQ_EVT  = `QS_SEL_FREQ_EVT,
    SEL_FREQ_MASK = `QS_SEL_FREQ_MASK,
    SEL_MOD_COND  = `QS_SEL_MOD_COND,
    SEL_MOD_RISE  = `QS_SEL_MOD_RISE,
    SEL_MOD_FALL  = `QS_SEL_MOD_FALL,
    SEL_MOD_EVT   = `QS_SEL_MOD_EVT,
    SEL_MOD_MASK  = `QS_SEL_MOD_MASK
  } reg_sel_t;
endpackage

// >>> include/status_group_if.sv
// signals of one status group between the register bank, edge filter and event latch
`timescale 1ns/10ps
`default_nettype none
interface status_group_if;
  import qstat_pkg::*;
  word_t cond;
  word_t rise_f;
  word_t fall_f;
  word_t set_v;
  logic  clear;
  word_t mask;
  word_t event_q;
  logic  summary;

  modport edge_side  (input cond, input rise_f, input fall_f, output set_v);
  modport latch_side (input set_v, input clear, input mask, output event_q, output summary);
  modport bank_side  (output cond, output rise_f, output fall_f, output clear, output mask,
                      input event_q, input summary);
endinterface
`default_nettype wire

// >>> design/edge_filter.sv
// per-bit transition detector gated by the rise and fall filters
`timescale 1ns/10ps
`default_nettype none
`include "qstat_regs.svh"
module edge_filter
  import qstat_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // group signals
  status_group_if.edge_side grp
);
  word_t           prev_q;
  wire [`QS_W-1:0] set_bits;

  // previous condition, so a change shows as one-cycle pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= `QS_ZERO;
    end else begin
      prev_q <= grp.cond;
    end
  end

  // each bit may record a rise, a fall, both or neither
  for (genvar i = 0; i < `QS_W; i++) begin : g_bit
    wire rise_seen = grp.cond[i] & ~prev_q[i];
    wire fall_seen = ~grp.cond[i] & prev_q[i];
    assign set_bits[i] = (rise_seen & grp.rise_f[i]) | (fall_seen & grp.fall_f[i]); // R11
  end

  // one driver for the whole interface word; per-bit drivers of a variable are refused
  assign grp.set_v = set_bits;
endmodule
`default_nettype wire

// >>> design/event_latch.sv
// sticky event bits with clear on read and a masked summary
`timescale 1ns/10ps
`default_nettype none
`include "qstat_regs.svh"
module event_latch
  import qstat_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // group signals
  status_group_if.latch_side grp
);
  word_t event_q;
  word_t event_d;
  logic  summary_q;
  logic  summary_d;

  // a set in the clearing cycle survives, so no edge is lost to a read
  assign event_d   = (grp.clear ? `QS_ZERO : event_q) | grp.set_v; // R13 R14
  assign summary_d = |(event_d & grp.mask); // R22

  always_ff @(posedge clk) begin
    if (reset) begin
      event_q   <= `QS_ZERO;
      summary_q <= 1'b0;
    end else begin
      event_q   <= event_d;
      summary_q <= summary_d;
    end
  end

  assign grp.event_q = event_q;
  assign grp.summary = summary_q;
endmodule
`default_nettype wire

// >>> design/questionable_freq_mod_status.sv
// frequency-lock and modulation-level questionable status groups with command access
`timescale 1ns/10ps
`default_nettype none
`include "qstat_regs.svh"
module questionable_freq_mod_status
  import qstat_pkg::*;
#(
  // variant options: a missing source forces its bit to zero
  parameter bit HAS_REF1G   = 1'b1,
  parameter bit HAS_BB1     = 1'b1,
  parameter bit HAS_SAMPLER = 1'b1,
  parameter bit HAS_YIG     = 1'b1
) (
  // clock and reset
  input wire logic  clk,
  input wire logic  reset,
  // frequency lock detectors, high while unlocked
  input wire logic  synth_unlock,
  input wire logic  ref10_unlock,
  input wire logic  ref1g_unlock,
  input wire logic  baseband1_unlock,
  input wire logic  sampler_loop_unlock,
  input wire logic  yig_oscillator_loop_unlock,
  // modulation level detectors, high while out of range
  input wire logic  ext1_level_low,
  input wire logic  ext1_level_high,
  input wire logic  ext2_level_low,
  input wire logic  ext2_level_high,
  input wire logic  mod_uncalibrated,
  // command port from the remote command parser
  input wire logic  cmd_valid,
  input wire logic  cmd_write,
  input wire logic  [3:0] cmd_sel,
  input wire logic  [15:0] cmd_wdata,
  output logic      rsp_valid,
  output logic      [15:0] rsp_data,
  // summary bits into the parent questionable condition register
  output logic      freq_summary,
  output logic      mod_summary
);
  // command port: a cmd_valid pulse is taken on the edge that sees it and answered
  // by rsp_valid one clock later; commands may come back to back every clock.
  // writes to condition, event or unmapped selects are answered but change nothing.
  // condition reads return the registered word, one clock behind the detector pins.
  // an enabled edge sets its event bit two clocks after the pin moves, and a set
  // in the same clock as the clearing read survives that read.
  // summaries are registered; a mask write acts on them one clock later.

  // one signal bundle per status group, shared by its edge filter and event latch
  status_group_if freq_grp ();
  status_group_if mod_grp ();

  // condition words, next and registered
  word_t freq_cond_q;
  word_t freq_cond_d;
  word_t mod_cond_q;
  word_t mod_cond_d;
  // filter and mask registers
  word_t freq_rise_q;
  word_t freq_fall_q;
  word_t freq_mask_q;
  word_t mod_rise_q;
  word_t mod_fall_q;
  word_t mod_mask_q;
  // answer registers and read select
  logic  rsp_valid_q;
  word_t rsp_data_q;
  word_t rd_mux;

  // variant gating: a loop the variant lacks has no detector, so its bit is forced low
  wire ref1g_seen   = ref1g_unlock & HAS_REF1G; // R3
  wire bb1_seen     = baseband1_unlock & HAS_BB1; // R4
  wire sampler_seen = sampler_loop_unlock & HAS_SAMPLER; // R5
  wire yig_seen     = yig_oscillator_loop_unlock & HAS_YIG; // R6

  // frequency condition word; unused bits 4 and 7 to 15 stay zero
  always_comb begin
    freq_cond_d = `QS_ZERO; // R7 R8
    freq_cond_d[`QS_F_SYNTH]   = synth_unlock; // R1
    freq_cond_d[`QS_F_REF10]   = ref10_unlock; // R2
    freq_cond_d[`QS_F_REF1G]   = ref1g_seen; // R3
    freq_cond_d[`QS_F_BB1]     = bb1_seen; // R4
    freq_cond_d[`QS_F_SAMPLER] = sampler_seen; // R5
    freq_cond_d[`QS_F_YIG]     = yig_seen; // R6
  end

  // modulation condition inputs; thresholds are judged by the analog detectors
  always_comb begin
    mod_cond_d = `QS_ZERO; // R8
    mod_cond_d[`QS_M_EXT1_LOW]  = ext1_level_low; // R17
    mod_cond_d[`QS_M_EXT1_HIGH] = ext1_level_high; // R18
    mod_cond_d[`QS_M_EXT2_LOW]  = ext2_level_low; // R19
    mod_cond_d[`QS_M_EXT2_HIGH] = ext2_level_high; // R19
    mod_cond_d[`QS_M_UNCAL]     = mod_uncalibrated; // R20
  end

  // frequency condition register follows the inputs every clock and takes no writes;
  // registering keeps a pin glitch inside one clock from posing as an edge
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_cond_q <= `QS_ZERO;
    end else begin
      freq_cond_q <= freq_cond_d & `QS_FREQ_USED; // R9
    end
  end

  // modulation condition register; the used-bit mask keeps bits 5 to 15 at zero
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_cond_q <= `QS_ZERO;
    end else begin
      mod_cond_q <= mod_cond_d & `QS_MOD_USED; // R9
    end
  end

  // command decode: each access names one register
  wire do_wr          = cmd_valid & cmd_write;
  wire do_rd          = cmd_valid & ~cmd_write;

  // one-hot register selects; codes outside the map match none of them
  wire sel_freq_cond  = (cmd_sel == SEL_FREQ_COND);
  wire sel_freq_rise  = (cmd_sel == SEL_FREQ_RISE);
  wire sel_freq_fall  = (cmd_sel == SEL_FREQ_FALL);
  wire sel_freq_evt   = (cmd_sel == SEL_FREQ_EVT);
  wire sel_freq_mask  = (cmd_sel == SEL_FREQ_MASK);
  wire sel_mod_cond   = (cmd_sel == SEL_MOD_COND);
  wire sel_mod_rise   = (cmd_sel == SEL_MOD_RISE);
  wire sel_mod_fall   = (cmd_sel == SEL_MOD_FALL);
  wire sel_mod_evt    = (cmd_sel == SEL_MOD_EVT);
  wire sel_mod_mask   = (cmd_sel == SEL_MOD_MASK);

  // write strobes; condition and event selects get none, so such writes are dropped
  wire wr_freq_rise   = do_wr & sel_freq_rise;
  wire wr_freq_fall   = do_wr & sel_freq_fall;
  wire wr_freq_mask   = do_wr & sel_freq_mask;
  wire wr_mod_rise    = do_wr & sel_mod_rise;
  wire wr_mod_fall    = do_wr & sel_mod_fall;
  wire wr_mod_mask    = do_wr & sel_mod_mask;
  // a read of an event register is also its clear
  wire rd_freq_evt    = do_rd & sel_freq_evt;
  wire rd_mod_evt     = do_rd & sel_mod_evt;

  // freq rise filter holds the summed bit weights as written; after reset every
  // rise is recorded, so an unlock present at power-up shows as an event
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_rise_q <= `QS_RISE_RST;
    end else if (wr_freq_rise) begin
      freq_rise_q <= cmd_wdata; // R12
    end
  end

  // freq fall filter; no fall is recorded until software asks for it
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_fall_q <= `QS_FALL_RST;
    end else if (wr_freq_fall) begin
      freq_fall_q <= cmd_wdata; // R12
    end
  end

  // freq summary mask; a new mask reaches the summary flip-flop on the next edge,
  // so the summary lags the write by one clock
  always_ff @(posedge clk) begin
    if (reset) begin
      freq_mask_q <= `QS_MASK_RST;
    end else if (wr_freq_mask) begin
      freq_mask_q <= cmd_wdata; // R12
    end
  end

  // mod rise filter
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_rise_q <= `QS_RISE_RST;
    end else if (wr_mod_rise) begin
      mod_rise_q <= cmd_wdata; // R12
    end
  end

  // mod fall filter
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_fall_q <= `QS_FALL_RST;
    end else if (wr_mod_fall) begin
      mod_fall_q <= cmd_wdata; // R12
    end
  end

  // mod summary mask; same one-clock lag as the frequency mask
  // and the only path by which modulation events reach the parent bit
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_mask_q <= `QS_MASK_RST;
    end else if (wr_mod_mask) begin
      mod_mask_q <= cmd_wdata; // R12
    end
  end

  // frequency group wiring: the event read doubles as the clear
  assign freq_grp.cond   = freq_cond_q;
  assign freq_grp.rise_f = freq_rise_q;
  assign freq_grp.fall_f = freq_fall_q;
  assign freq_grp.mask   = freq_mask_q; // R15
  assign freq_grp.clear  = rd_freq_evt; // R14

  // modulation group wiring
  assign mod_grp.cond    = mod_cond_q;
  assign mod_grp.rise_f  = mod_rise_q;
  assign mod_grp.fall_f  = mod_fall_q;
  assign mod_grp.mask    = mod_mask_q; // R21
  assign mod_grp.clear   = rd_mod_evt; // R14

  // frequency edges become one-clock set pulses
  edge_filter u_freq_edge (
    .clk   (clk),
    .reset (reset),
    .grp   (freq_grp)
  );

  // frequency events held until read, and the masked summary
  event_latch u_freq_evt (
    .clk   (clk),
    .reset (reset),
    .grp   (freq_grp)
  );

  // modulation edges
  edge_filter u_mod_edge (
    .clk   (clk),
    .reset (reset),
    .grp   (mod_grp)
  );

  // modulation events and summary
  event_latch u_mod_evt (
    .clk   (clk),
    .reset (reset),
    .grp   (mod_grp)
  );

  // read select: one masked term per register, so an unknown select reads zero;
  // the event terms see the word held before the edge that clears it
  wire [`QS_W-1:0] term_freq_cond = {`QS_W{sel_freq_cond}} & freq_cond_q; // R10
  wire [`QS_W-1:0] term_freq_rise = {`QS_W{sel_freq_rise}} & freq_rise_q;
  wire [`QS_W-1:0] term_freq_fall = {`QS_W{sel_freq_fall}} & freq_fall_q;
  wire [`QS_W-1:0] term_freq_evt  = {`QS_W{sel_freq_evt}} & freq_grp.event_q; // R14
  wire [`QS_W-1:0] term_freq_mask = {`QS_W{sel_freq_mask}} & freq_mask_q;
  wire [`QS_W-1:0] term_mod_cond  = {`QS_W{sel_mod_cond}} & mod_cond_q; // R10
  wire [`QS_W-1:0] term_mod_rise  = {`QS_W{sel_mod_rise}} & mod_rise_q;
  wire [`QS_W-1:0] term_mod_fall  = {`QS_W{sel_mod_fall}} & mod_fall_q;
  wire [`QS_W-1:0] term_mod_evt   = {`QS_W{sel_mod_evt}} & mod_grp.event_q; // R14
  wire [`QS_W-1:0] term_mod_mask  = {`QS_W{sel_mod_mask}} & mod_mask_q;

  // the selects are one-hot, so an or of the terms is the plain weighted word
  assign rd_mux = term_freq_cond
                | term_freq_rise
                | term_freq_fall
                | term_freq_evt
                | term_freq_mask
                | term_mod_cond
                | term_mod_rise
                | term_mod_fall
                | term_mod_evt
                | term_mod_mask;

  // every command is answered one clock later
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_valid;
    end
  end

  // answer data loads only with a command and then holds until the next answer,
  // so a slow parser still finds it; a write answers with zero data
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_data_q <= `QS_ZERO;
    end else if (cmd_valid) begin
      rsp_data_q <= do_rd ? rd_mux : `QS_ZERO;
    end
  end

  // answer outputs straight from flip-flops
  assign rsp_valid    = rsp_valid_q;
  assign rsp_data     = rsp_data_q;

  // summaries to the parent questionable register, glitch-free since both are registered
  assign freq_summary = freq_grp.summary; // R15 R22
  assign mod_summary  = mod_grp.summary; // R16 R21
endmodule
`default_nettype wire

// >>> bench/qstat_sva.sv
// port-level assertions for the questionable status bank
`timescale 1ns/10ps
`default_nettype none
module qstat_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // detectors
  input wire logic        synth_unlock,
  input wire logic        ref10_unlock,
  input wire logic        ref1g_unlock,
  input wire logic        baseband1_unlock,
  input wire logic        sampler_loop_unlock,
  input wire logic        yig_oscillator_loop_unlock,
  input wire logic        ext1_level_low,
  input wire logic        ext1_level_high,
  input wire logic        ext2_level_low,
  input wire logic        ext2_level_high,
  input wire logic        mod_uncalibrated,
  // command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [3:0]  cmd_sel,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  // summaries
  input wire logic        freq_summary,
  input wire logic        mod_summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // expected condition words and the commands that may drop a summary
  wire logic [15:0] f_now = {9'h000, yig_oscillator_loop_unlock, sampler_loop_unlock, 1'b0,
                             baseband1_unlock, ref1g_unlock, ref10_unlock, synth_unlock};
  wire logic [15:0] m_now = {11'h000, mod_uncalibrated, ext2_level_high, ext2_level_low,
                             ext1_level_high, ext1_level_low};
  wire logic        rd = cmd_valid && !cmd_write;
  wire logic        fclr = cmd_valid && (cmd_write ? cmd_sel == 4'h4 : cmd_sel == 4'h3);
  wire logic        mclr = cmd_valid && (cmd_write ? cmd_sel == 4'hc : cmd_sel == 4'hb);

  property p_rsp_once; cmd_valid |=> rsp_valid; endproperty
  a_rsp_once: assert property (p_rsp_once) else $error("command not answered");
  property p_rsp_only; !cmd_valid |=> !rsp_valid; endproperty
  a_rsp_only: assert property (p_rsp_only) else $error("answer without command");
  property p_wr_zero; cmd_valid && cmd_write |=> rsp_data == 16'h0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
  property p_fcond; rd && cmd_sel == 4'h0 && !$past(reset) |=> rsp_data == $past(f_now, 2);
  endproperty
  a_fcond: assert property (p_fcond) else $error("freq condition read wrong");
  property p_mcond; rd && cmd_sel == 4'h8 && !$past(reset) |=> rsp_data == $past(m_now, 2);
  endproperty
  a_mcond: assert property (p_mcond) else $error("mod condition read wrong");
  property p_unmap; cmd_valid && cmd_sel inside {4'h5, 4'h6, 4'h7, 4'hd, 4'he, 4'hf}
    |=> rsp_data == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped select not zero");
  property p_hold; !rsp_valid |-> $stable(rsp_data); endproperty
  a_hold: assert property (p_hold) else $error("answer data moved");
  property p_ffall; $fell(freq_summary) |-> $past(fclr) || $past(fclr, 2); endproperty
  a_ffall: assert property (p_ffall) else $error("freq summary fell");
  property p_mfall; $fell(mod_summary) |-> $past(mclr) || $past(mclr, 2); endproperty
  a_mfall: assert property (p_mfall) else $error("mod summary fell");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the questionable status bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import qstat_pkg::*;
  typedef struct packed { logic [10:0] hw; word_t f; word_t m; } row_t;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [10:0] hw = 11'h000;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [3:0]  cmd_sel = 4'h0;
  word_t       cmd_wdata = 16'h0000;
  logic        rsp_valid;
  word_t       rsp_data;
  logic        freq_summary;
  logic        mod_summary;
  int          miscompares = 0;
  int          n_tests = 0;
  // detector pattern beside the freq and mod condition words it gives
  row_t        rows [12] = '{
    '{11'h001, 16'h0001, 16'h0000},
    '{11'h002, 16'h0002, 16'h0000},
    '{11'h004, 16'h0004, 16'h0000},
    '{11'h008, 16'h0008, 16'h0000},
    '{11'h010, 16'h0020, 16'h0000},
    '{11'h020, 16'h0040, 16'h0000},
    '{11'h03f, 16'h006f, 16'h0000},
    '{11'h040, 16'h0000, 16'h0001},
    '{11'h080, 16'h0000, 16'h0002},
    '{11'h300, 16'h0000, 16'h000c},
    '{11'h400, 16'h0000, 16'h0010},
    '{11'h7ff, 16'h006f, 16'h001f}};

  always #2.5 clk = ~clk;

  questionable_freq_mod_status questionable_freq_mod_status_i (
    .clk(clk), .reset(reset), .synth_unlock(hw[0]), .ref10_unlock(hw[1]),
    .ref1g_unlock(hw[2]), .baseband1_unlock(hw[3]), .sampler_loop_unlock(hw[4]),
    .yig_oscillator_loop_unlock(hw[5]), .ext1_level_low(hw[6]), .ext1_level_high(hw[7]),
    .ext2_level_low(hw[8]), .ext2_level_high(hw[9]), .mod_uncalibrated(hw[10]),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .freq_summary(freq_summary),
    .mod_summary(mod_summary));

  task automatic chk(input string nm, input word_t seen, input word_t exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one command, answer sampled a step after the edge that raises it
  task automatic cmd(input logic w, input logic [3:0] s, input word_t d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_sel <= s;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
  endtask

  task automatic rd(input string nm, input logic [3:0] s, input word_t exp);
    cmd(1'b0, s, 16'h0000);
    chk(nm, rsp_data, exp);
  endtask

  // inputs need two edges to reach the events, one more gives margin
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task report_and_stop;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd("freq_event", 4'h3, 16'h0000);
    foreach (rows[i]) begin
      hw <= rows[i].hw;
      rd("freq_cond", 4'h0, rows[i].f);
      rd("mod_cond", 4'h8, rows[i].m);
    end
    // second reset mid-run brings filters and masks back
    @(posedge clk);
    hw <= 11'h000;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd("freq_rise", 4'h1, 16'h7fff);
    rd("freq_fall", 4'h2, 16'h0000);
    rd("freq_mask", 4'h4, 16'h0000);
    rd("mod_rise", 4'h9, 16'h7fff);
    rd("mod_fall", 4'ha, 16'h0000);
    rd("mod_mask", 4'hc, 16'h0000);
    cmd(1'b1, 4'h0, 16'hffff);
    rd("freq_cond", 4'h0, 16'h0000);
    cmd(1'b1, 4'h1, 16'h0021);
    cmd(1'b1, 4'h2, 16'h0040);
    cmd(1'b1, 4'h4, 16'h0001);
    rd("freq_rise", 4'h1, 16'h0021);
    // rises on bits 0, 1, 6: only bit 0 passes the rise filter
    hw <= 11'h023;
    settle;
    chk("freq_summary", {15'h0000, freq_summary}, 16'h0001);
    rd("freq_event", 4'h3, 16'h0001);
    @(posedge clk);
    #1;
    chk("freq_summary", {15'h0000, freq_summary}, 16'h0000);
    rd("freq_event", 4'h3, 16'h0000);
    // falls: only bit 6 is recorded, and it is masked off the summary
    hw <= 11'h000;
    settle;
    chk("freq_summary", {15'h0000, freq_summary}, 16'h0000);
    rd("freq_event", 4'h3, 16'h0040);
    cmd(1'b1, 4'hc, 16'h0010);
    hw <= 11'h400;
    settle;
    chk("mod_summary", {15'h0000, mod_summary}, 16'h0001);
    rd("mod_event", 4'hb, 16'h0010);
    // an enabled rise landing on the clearing edge of a read survives that read
    hw <= 11'h401;
    rd("freq_event", 4'h3, 16'h0000);
    rd("freq_event", 4'h3, 16'h0001);
    rd("unmapped", 4'h5, 16'h0000);
    report_and_stop;
  end
endmodule

bind questionable_freq_mod_status qstat_sva qstat_sva_i (
  .clk(clk), .reset(reset), .synth_unlock(synth_unlock), .ref10_unlock(ref10_unlock),
  .ref1g_unlock(ref1g_unlock), .baseband1_unlock(baseband1_unlock),
  .sampler_loop_unlock(sampler_loop_unlock),
  .yig_oscillator_loop_unlock(yig_oscillator_loop_unlock), .ext1_level_low(ext1_level_low),
  .ext1_level_high(ext1_level_high), .ext2_level_low(ext2_level_low),
  .ext2_level_high(ext2_level_high), .mod_uncalibrated(mod_uncalibrated),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .freq_summary(freq_summary),
  .mod_summary(mod_summary));
`default_nettype wire
